/* File: design/tcp_timer_pwm_defs.vh */
`ifndef TCP_TIMER_PWM_DEFS_VH
`define TCP_TIMER_PWM_DEFS_VH

// counter and channel widths
`define TCP_CNT_W        16
`define TCP_CHAN_N       4
`define TCP_PRESC_W      7

// reset values
`define TCP_CNT_RST      16'h0000
`define TCP_MOD_RST      16'hffff
`define TCP_CHAN_RST     16'h0000
`define TCP_PRESC_RST    7'h00

// prescaler select codes; the top code selects the external clock, which is not in the block, so the count holds
`define TCP_PS_DIV1      3'h0
`define TCP_PS_DIV2      3'h1
`define TCP_PS_DIV4      3'h2
`define TCP_PS_DIV8      3'h3
`define TCP_PS_DIV16     3'h4
`define TCP_PS_DIV32     3'h5
`define TCP_PS_DIV64     3'h6
`define TCP_PS_EXT       3'h7

// prescaler tap masks
`define TCP_MASK_DIV1    7'h00
`define TCP_MASK_DIV2    7'h01
`define TCP_MASK_DIV4    7'h03
`define TCP_MASK_DIV8    7'h07
`define TCP_MASK_DIV16   7'h0f
`define TCP_MASK_DIV32   7'h1f
`define TCP_MASK_DIV64   7'h3f

// edge/level select pair {hi,lo}
`define TCP_ELS_OFF      2'h0
`define TCP_ELS_TOGGLE   2'h1
`define TCP_ELS_CLEAR    2'h2
`define TCP_ELS_SET      2'h3

// pair members: even channel leads, odd channel buffers
`define TCP_PAIR0_EVEN   0
`define TCP_PAIR0_ODD    1
`define TCP_PAIR2_EVEN   2
`define TCP_PAIR2_ODD    3

`endif

/* File: design/tcp_timer_pwm.v */
// Function
// - channel writes replace compare value directly
// - compare only when counter equals value
// - compare flag at match, overflow per period
// - pair 0 link buffers channel 1 into 0
// - pair 2 link buffers channel 3 into 2
// - overflow selects most recently written set
// - pair 0 linked: channel 1 idle, pin released
// - pair 2 linked: channel 3 idle, pin released
// - toggle on overflow sets PWM period
// - pulse width runs overflow to compare
// - modulo 255 undivided gives 256 clocks
// - value 128 of 256 gives half duty
// - buffered width changes at next period
// - clear 1:0, set 1:1, complement level
// - no overflow toggle gives zero duty
// - full duty bit without toggle gives 100%
// - overflow flag on rollover after modulo
// - channel flag on each compare event
`include "tcp_timer_pwm_defs.vh"

module tcp_timer_pwm #(
  parameter CNT_W  = `TCP_CNT_W,
  parameter CHAN_N = `TCP_CHAN_N
) (
  input  wire               ref_clk,
  input  wire               rst_n,
  input  wire               counter_stop,
  input  wire               counter_reset,
  input  wire [2:0]         prescale_sel,
  input  wire               modulo_wr,
  input  wire [CNT_W-1:0]   modulo_wdata,
  input  wire               overflow_int_en,
  input  wire               overflow_flag_clear,
  input  wire [CHAN_N-1:0]  chan_value_wr,
  input  wire [CNT_W-1:0]   chan_value_wdata,
  input  wire [CHAN_N-1:0]  chan_mode_select_hi,
  input  wire [CHAN_N-1:0]  chan_mode_select_lo,
  input  wire [CHAN_N-1:0]  edge_level_select_hi,
  input  wire [CHAN_N-1:0]  edge_level_select_lo,
  input  wire [CHAN_N-1:0]  toggle_on_overflow,
  input  wire [CHAN_N-1:0]  chan_full_duty,
  input  wire [CHAN_N-1:0]  chan_int_en,
  input  wire [CHAN_N-1:0]  chan_flag_clear,
  output reg  [CNT_W-1:0]   counter_value,
  output reg                overflow_flag,
  output reg                overflow_irq,
  output reg  [CHAN_N-1:0]  chan_event_flag,
  output reg  [CHAN_N-1:0]  chan_irq,
  output reg  [CHAN_N-1:0]  chan_pin_out,
  output reg  [CHAN_N-1:0]  chan_pin_oe,
  output reg  [1:0]         pair_odd_active
);

  reg [`TCP_PRESC_W-1:0] presc;
  reg [CNT_W-1:0]        modulo_value;
  reg [CNT_W-1:0]        chan_value [0:CHAN_N-1];
  reg [1:0]              pair_last_odd;

  reg                    tick;
  reg                    ovf;
  reg [CNT_W-1:0]        next_cnt;
  reg [`TCP_PRESC_W-1:0] next_presc;
  reg [CHAN_N-1:0]       pair_linked;
  reg [CHAN_N-1:0]       cmp_en;
  reg [CHAN_N-1:0]       cmp_hit;
  reg [CNT_W-1:0]        act_val [0:CHAN_N-1];
  reg [CHAN_N-1:0]       next_pin;
  reg [CHAN_N-1:0]       next_oe;
  reg [CHAN_N-1:0]       next_chan_flag;
  reg                    next_ovf_flag;
  reg [1:0]              next_last_odd;
  reg [1:0]              next_odd_active;
  integer                i;
  integer                j;

  // tap mask of the prescaler for a select code
  function [`TCP_PRESC_W-1:0] presc_mask;
    input [2:0] ps;
    begin
      case (ps)
        `TCP_PS_DIV1:  presc_mask = `TCP_MASK_DIV1;
        `TCP_PS_DIV2:  presc_mask = `TCP_MASK_DIV2;
        `TCP_PS_DIV4:  presc_mask = `TCP_MASK_DIV4;
        `TCP_PS_DIV8:  presc_mask = `TCP_MASK_DIV8;
        `TCP_PS_DIV16: presc_mask = `TCP_MASK_DIV16;
        `TCP_PS_DIV32: presc_mask = `TCP_MASK_DIV32;
        `TCP_PS_DIV64: presc_mask = `TCP_MASK_DIV64;
        default:       presc_mask = `TCP_MASK_DIV64;
      endcase
    end
  endfunction

  // pin level after a compare action
  function compare_action;
    input [1:0] els;
    input       pin;
    begin
      case (els)
        `TCP_ELS_TOGGLE: compare_action = ~pin;
        `TCP_ELS_CLEAR:  compare_action = 1'b0;
        `TCP_ELS_SET:    compare_action = 1'b1;
        default:         compare_action = pin;
      endcase
    end
  endfunction

  // counter timebase
  always @* begin
    if (prescale_sel == `TCP_PS_EXT) begin
      // external clock input lives outside this block, so the count holds
      tick = 1'b0;
    end else begin
      tick = ~counter_stop &
             ((presc & presc_mask(prescale_sel)) == presc_mask(prescale_sel));
    end
    if (counter_reset) begin
      tick = 1'b0;
    end
    if (counter_reset || tick) begin
      next_presc = `TCP_PRESC_RST;
    end else if (counter_stop) begin
      next_presc = presc;
    end else begin
      next_presc = presc + 7'h01;
    end
    // period is modulo plus one ticks: 255 undivided is 256 clocks
    ovf = tick & (counter_value == modulo_value);
    if (counter_reset || ovf) begin
      next_cnt = `TCP_CNT_RST;
    end else if (tick) begin
      next_cnt = counter_value + 16'h0001;
    end else begin
      next_cnt = counter_value;
    end
  end

  // pair bookkeeping
  always @* begin
    pair_linked = {chan_mode_select_hi[`TCP_PAIR2_EVEN],
                   chan_mode_select_hi[`TCP_PAIR2_EVEN],
                   chan_mode_select_hi[`TCP_PAIR0_EVEN],
                   chan_mode_select_hi[`TCP_PAIR0_EVEN]};
    next_last_odd = pair_last_odd;
    if (chan_value_wr[`TCP_PAIR0_EVEN]) begin
      next_last_odd[0] = 1'b0;
    end
    if (chan_value_wr[`TCP_PAIR0_ODD]) begin
      next_last_odd[0] = 1'b1;
    end
    if (chan_value_wr[`TCP_PAIR2_EVEN]) begin
      next_last_odd[1] = 1'b0;
    end
    if (chan_value_wr[`TCP_PAIR2_ODD]) begin
      next_last_odd[1] = 1'b1;
    end
    next_odd_active = pair_odd_active;
    if (ovf) begin
      // same edge as the overflow toggle, so no period mixes two sets
      next_odd_active = next_last_odd;
    end
    if (!pair_linked[`TCP_PAIR0_EVEN]) begin
      next_last_odd[0] = 1'b0;
      next_odd_active[0] = 1'b0;
    end
    if (!pair_linked[`TCP_PAIR2_EVEN]) begin
      next_last_odd[1] = 1'b0;
      next_odd_active[1] = 1'b0;
    end
  end

  // per-channel compare and pin logic
  always @* begin
    next_ovf_flag = overflow_flag;
    if (overflow_flag_clear) begin
      next_ovf_flag = 1'b0;
    end
    if (ovf) begin
      next_ovf_flag = 1'b1;
    end
    for (i = 0; i < CHAN_N; i = i + 1) begin
      act_val[i] = chan_value[i];
      cmp_en[i] = chan_mode_select_hi[i] | chan_mode_select_lo[i];
      // take the selection that the overflow edge installs, so a compare at
      // count zero already belongs to the new period's register set
      if (i[0] == 1'b0 && pair_linked[i] && next_odd_active[i/2]) begin
        act_val[i] = chan_value[i+1];
      end
      if (i[0] == 1'b1 && pair_linked[i]) begin
        cmp_en[i] = 1'b0;
      end
      // next_cnt is what the counter shows after this edge
      cmp_hit[i] = tick & cmp_en[i] & (next_cnt == act_val[i]);
      next_pin[i] = chan_pin_out[i];
      if (ovf && toggle_on_overflow[i]) begin
        next_pin[i] = ~chan_pin_out[i];
      end
      if (cmp_hit[i]) begin
        // a compare on the overflow edge wins: width zero stays at zero
        next_pin[i] = compare_action({edge_level_select_hi[i],
                                      edge_level_select_lo[i]},
                                     next_pin[i]);
      end
      if (chan_full_duty[i] && !toggle_on_overflow[i]) begin
        // hold the pulse level, the complement of the compare action
        next_pin[i] = ~edge_level_select_lo[i];
      end
      // pin released to general use when idle or a buffer partner
      next_oe[i] = cmp_en[i] &
                   (edge_level_select_hi[i] | edge_level_select_lo[i]);
      next_chan_flag[i] = chan_event_flag[i];
      if (chan_flag_clear[i]) begin
        next_chan_flag[i] = 1'b0;
      end
      if (cmp_hit[i]) begin
        next_chan_flag[i] = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      presc           <= `TCP_PRESC_RST;
      counter_value   <= `TCP_CNT_RST;
      modulo_value    <= `TCP_MOD_RST;
      overflow_flag   <= 1'b0;
      overflow_irq    <= 1'b0;
      chan_event_flag <= {CHAN_N{1'b0}};
      chan_irq        <= {CHAN_N{1'b0}};
      chan_pin_out    <= {CHAN_N{1'b0}};
      chan_pin_oe     <= {CHAN_N{1'b0}};
      pair_last_odd   <= 2'h0;
      pair_odd_active <= 2'h0;
      for (j = 0; j < CHAN_N; j = j + 1) begin
        chan_value[j] <= `TCP_CHAN_RST;
      end
    end else begin
      presc           <= next_presc;
      counter_value   <= next_cnt;
      overflow_flag   <= next_ovf_flag;
      overflow_irq    <= next_ovf_flag & overflow_int_en;
      chan_event_flag <= next_chan_flag;
      chan_irq        <= next_chan_flag & chan_int_en;
      chan_pin_out    <= next_pin;
      chan_pin_oe     <= next_oe;
      pair_last_odd   <= next_last_odd;
      pair_odd_active <= next_odd_active;
      if (modulo_wr) begin
        modulo_value <= modulo_wdata;
      end
      // own loop index: the combinational loop must not share a driver
      for (j = 0; j < CHAN_N; j = j + 1) begin
        if (chan_value_wr[j]) begin
          // no shadow copy: the very next tick already compares on it
          chan_value[j] <= chan_value_wdata;
        end
      end
    end
  end

endmodule

/* File: test/tcp_timer_pwm_checker.sv */
module tcp_timer_pwm_checker #(
  parameter CNT_W  = 16,
  parameter CHAN_N = 4
) (
  input wire              ref_clk,
  input wire              rst_n,
  input wire              counter_stop,
  input wire              counter_reset,
  input wire [2:0]        prescale_sel,
  input wire              overflow_int_en,
  input wire [CHAN_N-1:0] chan_mode_select_hi,
  input wire [CHAN_N-1:0] chan_mode_select_lo,
  input wire [CHAN_N-1:0] edge_level_select_hi,
  input wire [CHAN_N-1:0] edge_level_select_lo,
  input wire [CHAN_N-1:0] toggle_on_overflow,
  input wire [CHAN_N-1:0] chan_full_duty,
  input wire [CHAN_N-1:0] chan_int_en,
  input wire [CNT_W-1:0]  counter_value,
  input wire              overflow_flag,
  input wire              overflow_irq,
  input wire [CHAN_N-1:0] chan_event_flag,
  input wire [CHAN_N-1:0] chan_irq,
  input wire [CHAN_N-1:0] chan_pin_out,
  input wire [CHAN_N-1:0] chan_pin_oe,
  input wire [1:0]        pair_odd_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wrap;
    counter_value != 0 && !counter_reset ##1 counter_value == 0;
  endsequence
  sequence s_flat0;
    !toggle_on_overflow[0] && !chan_full_duty[0] && chan_mode_select_lo[0]
      && edge_level_select_hi[0] && !edge_level_select_lo[0] && !chan_pin_out[0];
  endsequence
  chk_ovf_set: assert property (s_wrap |-> overflow_flag)
    else $error("overflow flag missing at wrap");
  chk_ovf_irq: assert property (overflow_irq == (overflow_flag & $past(overflow_int_en)))
    else $error("overflow request mismatch");
  chk_chan_irq: assert property (chan_irq == (chan_event_flag & $past(chan_int_en)))
    else $error("channel request mismatch");
  chk_cnt_step: assert property (!counter_stop && !counter_reset && prescale_sel == 3'h0
    |=> counter_value == $past(counter_value) + 1 || counter_value == 0)
    else $error("counter step wrong");
  chk_link0_oe: assert property (chan_mode_select_hi[0] |=> !chan_pin_oe[1])
    else $error("linked pin 1 driven");
  chk_link2_oe: assert property (chan_mode_select_hi[2] |=> !chan_pin_oe[3])
    else $error("linked pin 3 driven");
  chk_zero_hold: assert property (s_flat0 |=> !chan_pin_out[0])
    else $error("zero duty pin moved");
  chk_full_duty: assert property (!toggle_on_overflow[0] && chan_full_duty[0]
    |=> chan_pin_out[0] == !$past(edge_level_select_lo[0]))
    else $error("full duty level wrong");
  chk_swap_edge: assert property ($rose(pair_odd_active[0]) || $rose(pair_odd_active[1])
    |-> counter_value == 0)
    else $error("pair swap off overflow");
  chk_cmp_tick: assert property ($rose(chan_event_flag[0])
    |-> counter_value != $past(counter_value))
    else $error("compare without count");
endmodule

/* File: test/tcp_sw_model.sv */
module tcp_sw_model (
  input  wire       ref_clk,
  input  wire       overflow_irq,
  input  wire [3:0] chan_irq,
  output reg        overflow_flag_clear,
  output reg  [3:0] chan_flag_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    overflow_flag_clear = 1'h0;
    chan_flag_clear = 4'h0;
  end
  // handlers only acknowledge; new values are written by the bench
  always @(negedge ref_clk) begin
    overflow_flag_clear <= overflow_irq;
    chan_flag_clear <= chan_irq;
  end
endmodule

/* File: test/tcp_timer_pwm_tb.sv */
module tcp_timer_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg         ref_clk = 1'h0, rst_n = 1'h0, counter_stop = 1'h1, counter_reset = 1'h0;
  reg         modulo_wr = 1'h0, overflow_int_en = 1'h1;
  reg  [2:0]  prescale_sel = 3'h0;
  reg  [15:0] modulo_wdata = 16'h00ff, chan_value_wdata = 16'h0000;
  reg  [3:0]  chan_value_wr = 4'h0, chan_mode_select_hi = 4'h0, chan_mode_select_lo = 4'h0;
  reg  [3:0]  edge_level_select_hi = 4'h0, edge_level_select_lo = 4'h0;
  reg  [3:0]  toggle_on_overflow = 4'h0, chan_full_duty = 4'h0, chan_int_en = 4'hf;
  wire        overflow_flag_clear, overflow_flag, overflow_irq;
  wire [3:0]  chan_flag_clear, chan_event_flag, chan_irq, chan_pin_out, chan_pin_oe;
  wire [15:0] counter_value;
  wire [1:0]  pair_odd_active;
  integer     errors = 0, n_tests = 0;
  tcp_timer_pwm dut_u (.*);
  tcp_sw_model sw_u (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_wrap;
    integer i;
    @(negedge ref_clk);
    for (i = 0; i < 600 && counter_value !== 16'h0000; i = i + 1) @(negedge ref_clk);
    if (i == 600) begin
      chk("wrap timeout", 1, 0);
      tally_and_finish;
    end
  endtask
  task automatic measure(input integer ch, output integer hi);
    integer i;
    wait_wrap;
    hi = 0;
    for (i = 0; i < 256; i = i + 1) begin
      hi = hi + chan_pin_out[ch];
      @(negedge ref_clk);
    end
    chk("period", 0, counter_value);
  endtask
  // an interrupt that never comes counts once and ends the run; 4 is overflow
  task automatic wait_irq(input integer ch);
    integer i;
    for (i = 0; i < 600 && (ch < 4 ? chan_irq[ch] : overflow_irq) !== 1'h1; i = i + 1)
      @(negedge ref_clk);
    if (i == 600) begin
      chk("irq timeout", 1, 0);
      tally_and_finish;
    end
  endtask
  task automatic write(input integer ch, input [15:0] v);
    chan_value_wdata = v;
    chan_value_wr[ch] = 1'h1;
    @(negedge ref_clk);
    chan_value_wr = 4'h0;
  endtask
  // stop, reset, period, width, then control; compare never toggles
  task automatic setup(input integer ch, input logic lo, input [15:0] v);
    {chan_mode_select_hi, chan_mode_select_lo, edge_level_select_hi} = 12'h000;
    {edge_level_select_lo, toggle_on_overflow, chan_full_duty} = 12'h000;
    counter_stop = 1'h1;
    counter_reset = 1'h1;
    @(negedge ref_clk);
    counter_reset = 1'h0;
    modulo_wr = 1'h1;
    @(negedge ref_clk);
    modulo_wr = 1'h0;
    write(ch, v);
    chan_mode_select_lo[ch] = 1'h1;
    toggle_on_overflow[ch] = 1'h1;
    edge_level_select_hi[ch] = 1'h1;
    edge_level_select_lo[ch] = lo;
    @(negedge ref_clk);
    counter_stop = 1'h0;
  endtask
  task automatic t_pwm(input integer ch, input logic lo, input [15:0] v, input integer exp);
    integer hi;
    setup(ch, lo, v);
    measure(ch, hi);
    chk("high time", exp, hi);
    chk("pin oe", 1, chan_pin_oe[ch]);
  endtask
  task automatic t_late;
    integer i, n;
    setup(0, 1'h0, 16'h00c0);
    wait_wrap;
    repeat (160) @(negedge ref_clk);
    write(0, 16'h0040);
    n = 0;
    for (i = 0; i < 400 && counter_value !== 16'h0000; i = i + 1) begin
      n = n + chan_irq[0];
      @(negedge ref_clk);
    end
    chk("late wrap", 1, i < 400);
    chk("missed cmp", 0, n);
    if (i == 400) begin
      tally_and_finish;
    end
    wait_irq(0);
    chk("cmp count", 16'h0040, counter_value);
  endtask
  task automatic t_buf(input integer p);
    integer hi;
    setup(p, 1'h0, 16'h0040);
    chan_mode_select_hi[p] = 1'h1;
    chan_mode_select_lo[p+1] = 1'h1;
    edge_level_select_hi[p+1] = 1'h1;
    measure(p, hi);
    chk("even width", 16'h0040, hi);
    repeat (100) @(negedge ref_clk);
    write(p + 1, 16'h00c0);
    chk("no mid swap", 0, pair_odd_active[p/2]);
    measure(p, hi);
    chk("odd width", 16'h00c0, hi);
    chk("odd active", 1, pair_odd_active[p/2]);
    chk("odd oe", 0, chan_pin_oe[p+1]);
  endtask
  task automatic t_flat;
    integer hi;
    setup(0, 1'h0, 16'h0080);
    toggle_on_overflow[0] = 1'h0;
    measure(0, hi);
    chk("zero duty", 0, hi);
    chan_full_duty[0] = 1'h1;
    measure(0, hi);
    chk("full duty", 256, hi);
  endtask
  // shorter width from the compare handler, longer from the overflow handler
  task automatic t_sync;
    integer hi;
    setup(2, 1'h0, 16'h0080);
    wait_irq(2);
    write(2, 16'h0040);
    measure(2, hi);
    chk("lowered width", 16'h0040, hi);
    wait_irq(4);
    chk("ovf irq at wrap", 0, counter_value);
    write(2, 16'h00c0);
    measure(2, hi);
    chk("raised width", 16'h00c0, hi);
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'h1;
    t_pwm(0, 1'h0, 16'h0080, 128);
    t_pwm(1, 1'h1, 16'h0040, 192);
    t_pwm(2, 1'h0, 16'h0010, 16);
    t_pwm(3, 1'h0, 16'h0000, 0);
    t_late;
    t_buf(0);
    t_buf(2);
    t_flat;
    t_sync;
    tally_and_finish;
  end
endmodule
bind tcp_timer_pwm tcp_timer_pwm_checker #(.CNT_W(CNT_W), .CHAN_N(CHAN_N)) chk_u (.*);
